/* File: core/crci_pkg.sv */
package crci_pkg;
  localparam int ID_W = 11;
  localparam logic [ID_W-1:0] QUERY_ID_OFS = 11'h001;
  localparam logic [ID_W-1:0] RESP_ID_OFS = 11'h002;
  localparam logic [15:0] OBJ_INDEX_BASE = 16'h2001;
  localparam logic [15:0] IDX_START_STOP = 16'h2353;
  localparam logic [15:0] IDX_SEL_VOLT = 16'h2354;
  localparam logic [15:0] IDX_SEL_CURR = 16'h2355;
  localparam logic [15:0] IDX_SEQ_START = 16'h235C;
  localparam logic [15:0] IDX_SEQ_END = 16'h235D;
  localparam logic [15:0] REG_REPEAT = 16'h035D;
  localparam logic [15:0] IDX_SUBMIT = 16'h235F;
  localparam logic [15:0] IDX_LIM_VOLT = 16'h21F5;
  localparam logic [15:0] IDX_LIM_CURR = 16'h21F6;
  localparam logic [15:0] IDX_LIM_POW = 16'h21F7;
  localparam logic [15:0] IDX_POINT_FIRST = 16'h2385;
  localparam logic [15:0] IDX_POINT_LAST = 16'h29A5;
  localparam logic [15:0] VAL_ON = 16'hFF00;
  localparam logic [15:0] VAL_OFF = 16'h0000;
  localparam int NUM_POINTS = 99;
  localparam int VALS_PER_POINT = 8;
  localparam logic [7:0] SUB_MAX = 8'h08;
  localparam logic [15:0] NOMINAL_MAX = 16'hCCCC;
  localparam logic [31:0] AB_NO_OBJECT = 32'h0602_0000;
  localparam logic [31:0] AB_NO_CMD = 32'h0604_0043;
  localparam logic [31:0] AB_NO_SUB = 32'h0609_9911;
  localparam logic [31:0] AB_ACCESS = 32'h0601_0002;
  localparam logic [31:0] AB_TOO_MUCH = 32'h0607_0012;
  localparam logic [31:0] AB_TOO_LITTLE = 32'h0607_0013;
  localparam logic [31:0] AB_RANGE = 32'h0609_0030;
  localparam logic [31:0] AB_STATE = 32'h0800_0022;
  localparam logic [31:0] AB_NO_MEM = 32'h0504_0005;
  localparam logic [31:0] AB_GENERAL = 32'h0800_0000;
  localparam logic [15:0] ERR_REG = 16'hFFFF;
  localparam logic [3:0] DLC_WRITE = 4'h4;
  localparam logic [3:0] DLC_QUERY = 4'h2;
  localparam logic [3:0] DLC_RESP = 4'h4;
  localparam logic [3:0] DLC_ERR = 4'h6;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [3:0] dlc;
    logic [15:0] obj;
    logic [7:0] sub;
    logic [15:0] value;
  } crci_frame_t;

  typedef enum logic [3:0] {
    CRCI_IDLE = 4'b0001,
    CRCI_EXEC = 4'b0010,
    CRCI_LOAD = 4'b0100,
    CRCI_SEND = 4'b1000
  } crci_state_t;
endpackage : crci_pkg

/* File: core/crci_point_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module crci_point_mem #(
  parameter int DEPTH = 792,
  parameter int AW = 10
) (
  input wire logic core_clk_i, // Clock
  input wire logic we_i, // Write enable
  input wire logic [AW-1:0] waddr_i, // Write address
  input wire logic [15:0] wdata_i, // Write data
  input wire logic [AW-1:0] raddr_i, // Read address
  output logic [15:0] rdata_o // Registered read data
);
  // Starts all zero, so a generator that never saw a submit reads zeros
  logic [15:0] mem [DEPTH] = '{default: 16'h0000};

  always_ff @(posedge core_clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : crci_point_mem
`default_nettype wire

/* File: core/crci_top.sv */
// Overview of operation
// - Writes root, queries root+1, responses root+2
// - Query/response identifiers follow root changes
// - Group identifier accepts writes only
// - Bytes 0-1 carry object number
// - One sequence-point value per message
// - Each point value checked on arrival
// - Submit 0xFF00 loads generator, enables run
// - Unsubmitted points never reach generator
// - Points refused until U/I selected
// - 99 points at 2385..29A5, sub-indexed
// - Start/stop 2353; 0x0000 stops, 0x0000 at 2354/2355 leaves mode
// - Standard abort codes reported
// - Cyclic status sent once every CYCLIC_PERIOD cycles once active
// - Object index equals register plus 0x2001
`timescale 1ns/1ps
`default_nettype none
module crci_top
  import crci_pkg::*;
#(
  parameter int CYCLIC_PERIOD = 40000
) (
  input wire logic core_clk_i, // 40 MHz clock
  input wire logic srst_i, // Sync reset, high
  input wire logic [crci_pkg::ID_W-1:0] root_id_i, // Station identifier root
  input wire logic [crci_pkg::ID_W-1:0] group_id_i, // Group write identifier
  input wire logic [crci_pkg::ID_W-1:0] cyclic_id_i, // Cyclic status identifier
  input wire logic cyclic_en_i, // Cyclic status enabled
  input wire logic link_up_i, // CAN connection established
  input wire logic rx_valid_i, // Received frame strobe
  input wire crci_pkg::crci_frame_t rx_frame_i, // Received frame
  input wire logic tx_ready_i, // Transmitter free
  input wire logic [15:0] status_word_i, // Device status for cyclic frames
  input wire logic [9:0] gen_raddr_i, // Generator point read address
  output crci_pkg::crci_frame_t tx_frame_o, // Frame to send
  output logic tx_valid_o, // Frame valid
  output logic [15:0] gen_rdata_o, // Generator point data
  output logic gen_loaded_o, // Point data loaded
  output logic gen_run_o, // Generator running
  output logic mode_volt_o, // Waveform drives voltage
  output logic mode_curr_o, // Waveform drives current
  output logic [15:0] seq_start_o, // Start sequence point
  output logic [15:0] seq_end_o, // End sequence point
  output logic [15:0] repeat_o, // Repeat count
  output logic [15:0] lim_volt_o, // Global voltage limit
  output logic [15:0] lim_curr_o, // Global current limit
  output logic [15:0] lim_pow_o // Global power limit
);
  import crci_pkg::*;

  localparam int MEM_AW = 10;
  localparam int DEPTH = NUM_POINTS * VALS_PER_POINT;
  localparam logic [15:0] CYC_MAX = 16'(CYCLIC_PERIOD - 1);
  localparam int PT_STRIDE = (IDX_POINT_LAST - IDX_POINT_FIRST) / (NUM_POINTS - 1);

  // ------------------------------------------------------------
  // Frame classification
  // ------------------------------------------------------------
  crci_state_t state_reg;
  crci_frame_t cmd_reg;
  logic cmd_is_query_reg;
  logic [31:0] abort_reg;
  logic abort_pend_reg;
  logic [15:0] rd_val_reg;
  logic staged_ok_reg;
  logic [MEM_AW-1:0] copy_cnt_reg;
  logic [15:0] cyc_cnt_reg;
  logic cyc_due_reg;

  logic hit_write;
  logic hit_query;
  logic [ID_W-1:0] query_id;
  logic [ID_W-1:0] resp_id;

  assign query_id = root_id_i + QUERY_ID_OFS;
  assign resp_id = root_id_i + RESP_ID_OFS;
  assign hit_write = (rx_frame_i.id == root_id_i) || (rx_frame_i.id == group_id_i);
  assign hit_query = (rx_frame_i.id == query_id) && (rx_frame_i.id != group_id_i);

  // ------------------------------------------------------------
  // Write and query checks
  // ------------------------------------------------------------
  logic is_point;
  logic [15:0] pt_num;
  logic [15:0] pt_ofs;
  logic [MEM_AW-1:0] stage_addr;
  logic [31:0] chk_code;
  logic [15:0] reg_num;

  assign reg_num = cmd_reg.obj - OBJ_INDEX_BASE;
  // Points sit one stride apart; indexes between them are no objects
  assign pt_ofs = cmd_reg.obj - IDX_POINT_FIRST;
  assign is_point = (cmd_reg.obj >= IDX_POINT_FIRST) && (cmd_reg.obj <= IDX_POINT_LAST)
                    && (16'(pt_ofs % PT_STRIDE) == 16'h0000);
  assign pt_num = 16'(pt_ofs / PT_STRIDE);
  assign stage_addr = MEM_AW'(pt_num[6:0] * VALS_PER_POINT) + MEM_AW'(cmd_reg.sub - 8'h01);

  always_comb
  begin
    chk_code = 32'h0000_0000;
    if (cmd_is_query_reg)
    begin
      if (cmd_reg.dlc != DLC_QUERY)
        chk_code = AB_TOO_MUCH;
      else if (cmd_reg.obj == IDX_SUBMIT)
        chk_code = AB_ACCESS;
      else if (!(is_point || cmd_reg.obj == IDX_START_STOP || cmd_reg.obj == IDX_SEL_VOLT
                 || cmd_reg.obj == IDX_SEL_CURR || cmd_reg.obj == IDX_SEQ_START
                 || cmd_reg.obj == IDX_SEQ_END || reg_num == REG_REPEAT
                 || cmd_reg.obj == IDX_LIM_VOLT || cmd_reg.obj == IDX_LIM_CURR
                 || cmd_reg.obj == IDX_LIM_POW))
        chk_code = AB_NO_OBJECT;
    end
    else if (cmd_reg.dlc > DLC_WRITE + 4'h2)
      chk_code = AB_TOO_MUCH;
    else if (cmd_reg.dlc < DLC_WRITE)
      chk_code = AB_TOO_LITTLE;
    else if (is_point)
    begin
      if (!(mode_volt_o || mode_curr_o))
        chk_code = AB_STATE;
      else if (cmd_reg.sub == 8'h00 || cmd_reg.sub > SUB_MAX)
        chk_code = AB_NO_SUB;
      else if (cmd_reg.value > NOMINAL_MAX)
        chk_code = AB_RANGE;
    end
    else if (cmd_reg.obj == IDX_SUBMIT)
    begin
      if (cmd_reg.value != VAL_ON)
        chk_code = AB_NO_CMD;
      else if (!staged_ok_reg)
        chk_code = AB_STATE;
    end
    else if (cmd_reg.obj == IDX_START_STOP)
    begin
      if (!gen_loaded_o)
        chk_code = AB_STATE;
      else if (cmd_reg.value != VAL_ON && cmd_reg.value != VAL_OFF)
        chk_code = AB_NO_CMD;
    end
    else if (cmd_reg.obj == IDX_SEL_VOLT || cmd_reg.obj == IDX_SEL_CURR)
    begin
      if (cmd_reg.value != VAL_ON && cmd_reg.value != VAL_OFF)
        chk_code = AB_NO_CMD;
      else if (cmd_reg.value == VAL_ON && (mode_volt_o || mode_curr_o))
        chk_code = AB_STATE;
    end
    else if (cmd_reg.obj == IDX_SEQ_START || cmd_reg.obj == IDX_SEQ_END)
    begin
      if (cmd_reg.value >= 16'(NUM_POINTS))
        chk_code = AB_RANGE;
    end
    else if (cmd_reg.obj == IDX_LIM_VOLT || cmd_reg.obj == IDX_LIM_CURR
             || cmd_reg.obj == IDX_LIM_POW)
    begin
      if (cmd_reg.value > NOMINAL_MAX)
        chk_code = AB_RANGE;
    end
    else if (reg_num != REG_REPEAT)
      chk_code = AB_NO_OBJECT;
  end

  logic exec_ok;
  assign exec_ok = (state_reg == CRCI_EXEC) && !cmd_is_query_reg && (chk_code == 32'h0000_0000);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state_reg <= CRCI_IDLE;
      cmd_reg <= '0;
      cmd_is_query_reg <= 1'b0;
      copy_cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        CRCI_IDLE:
        begin
          if (rx_valid_i && (hit_write || hit_query) && !abort_pend_reg && !cyc_due_reg)
          begin
            cmd_reg <= rx_frame_i;
            cmd_is_query_reg <= hit_query;
            state_reg <= CRCI_EXEC;
          end
        end
        CRCI_EXEC:
        begin
          copy_cnt_reg <= '0;
          if (exec_ok && cmd_reg.obj == IDX_SUBMIT)
            state_reg <= CRCI_LOAD;
          else if (cmd_is_query_reg || chk_code != 32'h0000_0000)
            state_reg <= CRCI_SEND;
          else
            state_reg <= CRCI_IDLE;
        end
        CRCI_LOAD:
        begin
          copy_cnt_reg <= copy_cnt_reg + MEM_AW'(1);
          if (copy_cnt_reg == MEM_AW'(DEPTH))
            state_reg <= CRCI_IDLE;
        end
        CRCI_SEND:
        begin
          if (!tx_valid_o)
            state_reg <= CRCI_IDLE;
        end
        default:
        begin
          state_reg <= CRCI_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Object store, updated only by checked writes
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      mode_volt_o <= 1'b0;
      mode_curr_o <= 1'b0;
      gen_run_o <= 1'b0;
      seq_start_o <= '0;
      seq_end_o <= '0;
      repeat_o <= '0;
      lim_volt_o <= '0;
      lim_curr_o <= '0;
      lim_pow_o <= '0;
    end
    else if (exec_ok)
    begin
      if (cmd_reg.obj == IDX_SEL_VOLT)
      begin
        mode_volt_o <= (cmd_reg.value == VAL_ON);
        if (cmd_reg.value == VAL_OFF)
          gen_run_o <= 1'b0;
      end
      if (cmd_reg.obj == IDX_SEL_CURR)
      begin
        mode_curr_o <= (cmd_reg.value == VAL_ON);
        if (cmd_reg.value == VAL_OFF)
          gen_run_o <= 1'b0;
      end
      if (cmd_reg.obj == IDX_START_STOP)
        gen_run_o <= (cmd_reg.value == VAL_ON);
      if (cmd_reg.obj == IDX_SEQ_START)
        seq_start_o <= cmd_reg.value;
      if (cmd_reg.obj == IDX_SEQ_END)
        seq_end_o <= cmd_reg.value;
      if (reg_num == REG_REPEAT)
        repeat_o <= cmd_reg.value;
      if (cmd_reg.obj == IDX_LIM_VOLT)
        lim_volt_o <= cmd_reg.value;
      if (cmd_reg.obj == IDX_LIM_CURR)
        lim_curr_o <= cmd_reg.value;
      if (cmd_reg.obj == IDX_LIM_POW)
        lim_pow_o <= cmd_reg.value;
    end
  end

  // Staging tracks whether any point arrived since the last submit
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      staged_ok_reg <= 1'b0;
    else if (exec_ok && is_point)
      staged_ok_reg <= 1'b1;
    else if (state_reg == CRCI_LOAD)
      staged_ok_reg <= 1'b0;
  end

  // Loaded flag drops when waveform mode is left
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      gen_loaded_o <= 1'b0;
    else if (state_reg == CRCI_LOAD && copy_cnt_reg == MEM_AW'(DEPTH))
      gen_loaded_o <= 1'b1;
    else if (exec_ok && (cmd_reg.obj == IDX_SEL_VOLT || cmd_reg.obj == IDX_SEL_CURR)
             && cmd_reg.value == VAL_OFF)
      gen_loaded_o <= 1'b0;
  end

  // ------------------------------------------------------------
  // Point memories: staging and active copy
  // ------------------------------------------------------------
  logic [15:0] stage_rdata;
  logic [MEM_AW-1:0] stage_raddr;
  logic act_we;

  // Copy lags read by one cycle for the registered read data
  assign stage_raddr = (state_reg == CRCI_LOAD) ? copy_cnt_reg : stage_addr;
  assign act_we = (state_reg == CRCI_LOAD) && (copy_cnt_reg != '0);

  crci_point_mem #(.DEPTH(DEPTH), .AW(MEM_AW)) u_stage (
    .core_clk_i(core_clk_i),
    .we_i(exec_ok && is_point),
    .waddr_i(stage_addr),
    .wdata_i(cmd_reg.value),
    .raddr_i(stage_raddr),
    .rdata_o(stage_rdata)
  );

  crci_point_mem #(.DEPTH(DEPTH), .AW(MEM_AW)) u_active (
    .core_clk_i(core_clk_i),
    .we_i(act_we),
    .waddr_i(copy_cnt_reg - MEM_AW'(1)),
    .wdata_i(stage_rdata),
    .raddr_i(gen_raddr_i),
    .rdata_o(gen_rdata_o)
  );

  // ------------------------------------------------------------
  // Query read value
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      rd_val_reg <= '0;
    else if (state_reg == CRCI_EXEC)
    begin
      if (cmd_reg.obj == IDX_SEL_VOLT)
        rd_val_reg <= mode_volt_o ? VAL_ON : VAL_OFF;
      else if (cmd_reg.obj == IDX_SEL_CURR)
        rd_val_reg <= mode_curr_o ? VAL_ON : VAL_OFF;
      else if (cmd_reg.obj == IDX_START_STOP)
        rd_val_reg <= gen_run_o ? VAL_ON : VAL_OFF;
      else if (cmd_reg.obj == IDX_SEQ_START)
        rd_val_reg <= seq_start_o;
      else if (cmd_reg.obj == IDX_SEQ_END)
        rd_val_reg <= seq_end_o;
      else if (cmd_reg.obj == IDX_LIM_VOLT)
        rd_val_reg <= lim_volt_o;
      else if (cmd_reg.obj == IDX_LIM_CURR)
        rd_val_reg <= lim_curr_o;
      else if (cmd_reg.obj == IDX_LIM_POW)
        rd_val_reg <= lim_pow_o;
      else
        rd_val_reg <= repeat_o;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      abort_reg <= '0;
      abort_pend_reg <= 1'b0;
    end
    else if (state_reg == CRCI_EXEC)
    begin
      abort_reg <= chk_code;
      abort_pend_reg <= (chk_code != 32'h0000_0000);
    end
    else if (tx_valid_o && tx_ready_i && tx_frame_o.obj == ERR_REG)
      abort_pend_reg <= 1'b0;
  end

  // ------------------------------------------------------------
  // Cyclic status timer
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || !(cyclic_en_i && link_up_i))
    begin
      cyc_cnt_reg <= '0;
      cyc_due_reg <= 1'b0;
    end
    else
    begin
      cyc_cnt_reg <= (cyc_cnt_reg == CYC_MAX) ? 16'h0000 : cyc_cnt_reg + 16'h0001;
      if (cyc_cnt_reg == CYC_MAX)
        cyc_due_reg <= 1'b1;
      else if (tx_valid_o && tx_ready_i && tx_frame_o.id == cyclic_id_i)
        cyc_due_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Transmit
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      tx_valid_o <= 1'b0;
      tx_frame_o <= '0;
    end
    else if (tx_valid_o)
    begin
      if (tx_ready_i)
        tx_valid_o <= 1'b0;
    end
    else if (state_reg == CRCI_SEND && abort_pend_reg)
    begin
      tx_valid_o <= 1'b1;
      tx_frame_o <= '{id: resp_id, dlc: DLC_ERR, obj: ERR_REG,
                      sub: abort_reg[31:24], value: abort_reg[15:0]};
    end
    else if (state_reg == CRCI_SEND)
    begin
      tx_valid_o <= 1'b1;
      // Staging read data settle one cycle after EXEC, so take them here
      tx_frame_o <= '{id: resp_id, dlc: DLC_RESP, obj: cmd_reg.obj,
                      sub: cmd_reg.sub, value: is_point ? stage_rdata : rd_val_reg};
    end
    else if (state_reg == CRCI_IDLE && cyc_due_reg)
    begin
      tx_valid_o <= 1'b1;
      tx_frame_o <= '{id: cyclic_id_i, dlc: DLC_QUERY, obj: status_word_i,
                      sub: 8'h00, value: 16'h0000};
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_resp_id;
    @(posedge core_clk_i) disable iff (srst_i)
      (tx_valid_o && tx_frame_o.id != cyclic_id_i) |-> tx_frame_o.id == root_id_i + RESP_ID_OFS;
  endproperty
  a_resp_id: assert property (p_resp_id) else $error("response id wrong");

  property p_no_point_unselected;
    @(posedge core_clk_i) disable iff (srst_i)
      (exec_ok && is_point) |-> (mode_volt_o || mode_curr_o);
  endproperty
  a_no_point_unselected: assert property (p_no_point_unselected) else $error("point taken");

  property p_range_abort;
    @(posedge core_clk_i) disable iff (srst_i)
      (state_reg == CRCI_EXEC && !cmd_is_query_reg && is_point && (mode_volt_o || mode_curr_o)
       && cmd_reg.sub != 8'h00 && cmd_reg.sub <= SUB_MAX && cmd_reg.dlc == DLC_WRITE
       && cmd_reg.value > NOMINAL_MAX) |=> abort_reg == AB_RANGE;
  endproperty
  a_range_abort: assert property (p_range_abort) else $error("no range abort");

  property p_loaded_after_submit;
    @(posedge core_clk_i) disable iff (srst_i)
      (exec_ok && cmd_reg.obj == IDX_SUBMIT) |-> ##[1:800] gen_loaded_o;
  endproperty
  a_loaded_after_submit: assert property (p_loaded_after_submit) else $error("not loaded");

  property p_run_needs_load;
    @(posedge core_clk_i) disable iff (srst_i)
      $rose(gen_run_o) |-> $past(gen_loaded_o);
  endproperty
  a_run_needs_load: assert property (p_run_needs_load) else $error("run unloaded");

  property p_leave_mode;
    @(posedge core_clk_i) disable iff (srst_i)
      (exec_ok && cmd_reg.obj == IDX_SEL_VOLT && cmd_reg.value == VAL_OFF)
      |=> !mode_volt_o && !gen_run_o;
  endproperty
  a_leave_mode: assert property (p_leave_mode) else $error("mode kept");

  property p_fail_unchanged;
    @(posedge core_clk_i) disable iff (srst_i)
      (state_reg == CRCI_EXEC && chk_code != 32'h0000_0000 && cmd_reg.obj == IDX_LIM_POW)
      |=> $stable(lim_pow_o);
  endproperty
  a_fail_unchanged: assert property (p_fail_unchanged) else $error("changed on fail");

  property p_query_no_write;
    @(posedge core_clk_i) disable iff (srst_i)
      (state_reg == CRCI_EXEC && cmd_is_query_reg) |=> $stable(seq_start_o) && $stable(repeat_o);
  endproperty
  a_query_no_write: assert property (p_query_no_write) else $error("query wrote");

  property p_abort_sent;
    @(posedge core_clk_i) disable iff (srst_i)
      $rose(abort_pend_reg) |-> ##[1:3] (tx_valid_o && tx_frame_o.obj == ERR_REG);
  endproperty
  a_abort_sent: assert property (p_abort_sent) else $error("abort not sent");

  c_submit: cover property (@(posedge core_clk_i) disable iff (srst_i)
    exec_ok && cmd_reg.obj == IDX_SUBMIT);
  c_abort: cover property (@(posedge core_clk_i) disable iff (srst_i) $rose(abort_pend_reg));
  c_run: cover property (@(posedge core_clk_i) disable iff (srst_i) $rose(gen_run_o));
  c_cyclic: cover property (@(posedge core_clk_i) disable iff (srst_i)
    tx_valid_o && tx_frame_o.id == cyclic_id_i);
endmodule : crci_top
`default_nettype wire

/* File: tb/crci_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host controller on the far side of the bus
// ----------------------------------------
module crci_host_model
  import crci_pkg::*;
(
  input wire logic core_clk_i, // Clock
  input wire logic srst_i, // Sync reset, high
  input wire logic slow_i, // Stall each frame three cycles
  input wire crci_pkg::crci_frame_t tx_frame_i, // Frame offered by device
  input wire logic tx_valid_i, // Frame offered
  output logic tx_ready_o, // Frame taken this edge
  output crci_pkg::crci_frame_t got_o, // Last frame taken
  output logic [15:0] got_cnt_o // Frames taken so far
);
  logic [1:0] wait_reg;

  // Any frame is taken, asked for or not
  assign tx_ready_o = tx_valid_i && (!slow_i || wait_reg == 2'h3);

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || tx_ready_o || !tx_valid_i)
      wait_reg <= 2'h0;
    else
      wait_reg <= wait_reg + 2'h1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      got_o <= '0;
      got_cnt_o <= 16'h0000;
    end
    else if (tx_ready_o)
    begin
      got_o <= tx_frame_i;
      got_cnt_o <= got_cnt_o + 16'h0001;
    end
  end
endmodule : crci_host_model
`default_nettype wire

/* File: tb/crci_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module crci_top_tb_top;
  import crci_pkg::*;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [10:0] root = 11'h100;
  logic [10:0] grp = 11'h300;
  logic cyc_en = 1'b0;
  logic rx_valid = 1'b0;
  crci_frame_t rx_frame = '0;
  logic slow = 1'b0;
  logic [9:0] raddr = 10'h000;
  logic tx_ready, tx_valid, loaded, run, mv, mc;
  crci_frame_t tx_frame, got;
  logic [15:0] got_cnt, rdata, c0, s_st, s_en, rep, lv, lc, lp;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  initial
  begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // Short cyclic period keeps the status test brief
  crci_top #(.CYCLIC_PERIOD(20)) dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .root_id_i(root), .group_id_i(grp), .cyclic_id_i(11'h055), .cyclic_en_i(cyc_en),
    .link_up_i(1'b1), .rx_valid_i(rx_valid), .rx_frame_i(rx_frame), .tx_ready_i(tx_ready),
    .status_word_i(16'hA5A5), .gen_raddr_i(raddr), .tx_frame_o(tx_frame), .tx_valid_o(tx_valid),
    .gen_rdata_o(rdata), .gen_loaded_o(loaded), .gen_run_o(run), .mode_volt_o(mv),
    .mode_curr_o(mc), .seq_start_o(s_st), .seq_end_o(s_en), .repeat_o(rep), .lim_volt_o(lv),
    .lim_curr_o(lc), .lim_pow_o(lp));

  crci_host_model host_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .slow_i(slow),
    .tx_frame_i(tx_frame), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .got_o(got),
    .got_cnt_o(got_cnt));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [15:0] obj,
    input logic [7:0] sub, input logic [15:0] val);
    @(negedge core_clk_i);
    c0 = got_cnt;
    rx_frame = '{id, dlc, obj, sub, val};
    rx_valid = 1'b1;
    @(negedge core_clk_i);
    rx_valid = 1'b0;
    repeat (8) @(negedge core_clk_i);
  endtask : send

  task automatic wr(input logic [15:0] obj, input logic [15:0] val);
    send(root, DLC_WRITE, obj, 8'h00, val);
  endtask : wr

  // Exactly one new frame with this identifier and object
  task automatic expf(input logic [10:0] id, input logic [15:0] obj);
    int n;
    n = 0;
    while (got_cnt == c0 && n < 40)
    begin
      @(negedge core_clk_i);
      n++;
    end
    chk(got_cnt - c0, 32'h1);
    chk(got.id, id);
    chk(got.obj, obj);
  endtask : expf

  task automatic errf(input logic [31:0] ab);
    expf(root + RESP_ID_OFS, ERR_REG);
    chk(got.sub, ab[31:24]);
    chk(got.value, ab[15:0]);
  endtask : errf

  task automatic t_ids;
    wr(IDX_LIM_POW, 16'h1111);
    chk(lp, 16'h1111);
    chk(got_cnt - c0, 32'h0);
    send(grp, DLC_WRITE, IDX_LIM_VOLT, 8'h00, 16'h2222);
    chk(lv, 16'h2222);
    send(root + QUERY_ID_OFS, DLC_QUERY, IDX_LIM_POW, 8'h00, 16'h0000);
    expf(root + RESP_ID_OFS, IDX_LIM_POW);
    chk(got.value, 16'h1111);
    wr(IDX_LIM_POW, 16'hCCCD);
    errf(AB_RANGE);
    chk(lp, 16'h1111);
    wr(16'h2000, 16'h0001);
    errf(AB_NO_OBJECT);
    send(root, DLC_QUERY, IDX_LIM_POW, 8'h00, 16'h0000);
    errf(AB_TOO_LITTLE);
    send(root, 4'h8, IDX_LIM_POW, 8'h00, 16'h0000);
    errf(AB_TOO_MUCH);
    chk(lp, 16'h1111);
    $display("test ids done");
  endtask : t_ids

  task automatic t_root;
    root = 11'h200;
    slow = 1'b1;
    send(11'h201, DLC_QUERY, IDX_LIM_VOLT, 8'h00, 16'h0000);
    expf(11'h202, IDX_LIM_VOLT);
    chk(got.value, 16'h2222);
    slow = 1'b0;
    send(11'h101, DLC_QUERY, IDX_LIM_VOLT, 8'h00, 16'h0000);
    chk(got_cnt - c0, 32'h0);
    $display("test root done");
  endtask : t_root

  task automatic t_wave;
    int n;
    send(root, DLC_WRITE, IDX_POINT_FIRST, 8'h01, 16'h1234);
    errf(AB_STATE);
    wr(IDX_SEL_VOLT, VAL_ON);
    chk({mv, mc}, 32'h2);
    wr(IDX_SEQ_START, 16'h0002);
    wr(IDX_SEQ_END, 16'h0005);
    wr(OBJ_INDEX_BASE + REG_REPEAT, 16'h0003);
    chk({s_st, s_en}, 32'h0002_0005);
    chk(rep, 16'h0003);
    wr(IDX_LIM_CURR, 16'h0800);
    chk(lc, 16'h0800);
    send(root, DLC_WRITE, IDX_POINT_FIRST, 8'h01, 16'h1234);
    send(root, DLC_WRITE, IDX_POINT_FIRST, 8'h08, 16'hCCCC);
    send(root, DLC_WRITE, IDX_POINT_LAST, 8'h01, 16'h0777);
    send(root, DLC_WRITE, IDX_POINT_FIRST + 16'h0001, 8'h01, 16'h0001);
    errf(AB_NO_OBJECT);
    send(root, DLC_WRITE, IDX_POINT_FIRST, 8'h01, 16'hCCCD);
    errf(AB_RANGE);
    send(root, DLC_WRITE, IDX_POINT_LAST, 8'h09, 16'h0001);
    errf(AB_NO_SUB);
    wr(IDX_START_STOP, VAL_ON);
    errf(AB_STATE);
    chk({loaded, run, rdata}, 32'h0);
    send(root + QUERY_ID_OFS, DLC_QUERY, IDX_SUBMIT, 8'h00, 16'h0000);
    errf(AB_ACCESS);
    wr(IDX_SUBMIT, 16'h0001);
    errf(AB_NO_CMD);
    wr(IDX_SUBMIT, VAL_ON);
    n = 0;
    while (!loaded && n < 1000)
    begin
      @(negedge core_clk_i);
      n++;
    end
    chk(loaded, 1'b1);
    raddr = 10'h007;
    repeat (2) @(negedge core_clk_i);
    chk(rdata, 16'hCCCC);
    raddr = 10'h000;
    repeat (2) @(negedge core_clk_i);
    chk(rdata, 16'h1234);
    raddr = 10'h310;
    repeat (2) @(negedge core_clk_i);
    chk(rdata, 16'h0777);
    send(root + QUERY_ID_OFS, DLC_QUERY, IDX_POINT_FIRST, 8'h08, 16'h0000);
    expf(root + RESP_ID_OFS, IDX_POINT_FIRST);
    chk(got.value, 16'hCCCC);
    wr(IDX_START_STOP, VAL_ON);
    chk(run, 1'b1);
    wr(IDX_START_STOP, VAL_OFF);
    chk(run, 1'b0);
    wr(IDX_START_STOP, VAL_ON);
    wr(IDX_SEL_VOLT, VAL_OFF);
    chk({mv, run, loaded}, 32'h0);
    wr(IDX_SEL_CURR, VAL_ON);
    chk({mv, mc}, 32'h1);
    wr(IDX_SEL_CURR, VAL_ON);
    errf(AB_STATE);
    wr(IDX_SEL_CURR, VAL_OFF);
    chk(mc, 1'b0);
    $display("test wave done");
  endtask : t_wave

  task automatic t_cyclic;
    @(negedge core_clk_i);
    c0 = got_cnt;
    cyc_en = 1'b1;
    expf(11'h055, 16'hA5A5);
    cyc_en = 1'b0;
    $display("test cyclic done");
  endtask : t_cyclic

  task automatic conclude;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      conclude();
    end
  end

  initial
  begin
    repeat (3) @(negedge core_clk_i);
    srst_i = 1'b0;
    t_ids();
    t_root();
    t_wave();
    t_cyclic();
    conclude();
  end
endmodule : crci_top_tb_top
`default_nettype wire
